// ### src/ifrc_regs.sv
// Interrupt mapping, FIFO control and transceiver option registers behind APB
//
// Overview of operation
// - Rx continuous: pin0 level irq if sel 01
// - Rx buffered pin0: off, byte, nonempty, sync
// - Rx continuous: pin1 carries recovered bit clock
// - Rx buffered pin1: off, full, level irq
// - Tx buffered: pin1 full/stopped, pin0 nonempty
// - Read-only full and nonempty flags, irq sources
// - Sticky overrun; writing one clears, and flushes if it was set
// - Fill on sync, or while start bit high
// - Start bit set on sequence; one clears
// - Read-only transmission stopped flag, irq source
// - Tx starts on full, or on nonempty
// - Level interrupt only when enable bit set
// - Sticky level hit flag, one clears
// - Threshold codes 00/01 level one, 10, 11
// - Bit five set sends unmodulated carrier
// - Bit four enables data shaping filter
// - Bit sync normal or noisy select
// - Baseband width select, four codes
// - Force bit overrides width to widest
// - Sync compare: first bit against pattern MSB
//
// Added by the designer: register access over APB.
`timescale 1ns/1ns
`default_nettype none
module ifrc_regs
  import ifrc_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
) (
  // Clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Transceiver state
  input wire logic [1:0] chip_mode_i,
  input wire logic buffered_i,
  // FIFO status
  input wire logic fifo_full_i,
  input wire logic fifo_not_empty_i,
  input wire logic fifo_overrun_i,
  input wire logic byte_written_i,
  input wire logic tx_stopped_i,
  // Receive datapath
  input wire logic recovered_bit_clock_i,
  input wire logic demod_bit_i,
  input wire logic demod_bit_valid_i,
  input wire logic [31:0] pattern_i,
  input wire logic [1:0] pattern_size_i,
  input wire logic [1:0] power_level_i,
  // Interrupt pins
  output logic irq0_o,
  output logic irq1_o,
  // FIFO and transmit control
  output logic fifo_fill_en_o,
  output logic fifo_flush_o,
  output logic tx_start_o,
  output logic sync_match_o,
  // Radio options
  output logic [1:0] tx_power_sel_o,
  output logic carrier_only_o,
  output logic shaping_en_o,
  output logic bsync_noisy_o,
  output logic bitsync_off_o,
  output logic [1:0] baseband_width_sel_o,
  output logic widest_filter_force_o
);

  if (ADDR_W < 6) begin : g_chk
    $error("ADDR_W too narrow for the register map");
  end

  // Stored fields
  logic [1:0] rx_irq0_sel_q;
  logic [1:0] rx_irq1_sel_q;
  logic tx_irq1_sel_q;
  logic overrun_q;
  logic start_fill_q;
  logic start_detect_q;
  logic start_full_q;
  logic signal_level_irq_enable_q;
  logic signal_level_hit_flag_q;
  logic [1:0] signal_level_threshold_sel_q;
  logic [7:0] tx_opt_q;
  logic [7:0] rx_filt_q;
  logic [31:0] prdata_q;
  logic flush_q;
  logic irq0_q;
  logic irq1_q;

  // Bus decode
  logic access;
  logic setup;
  logic mapped;
  logic wr;
  logic [7:0] wbyte;
  logic [7:0] addr8;
  logic wr_irq_sel;
  logic wr_fill;
  logic wr_tx;
  logic wr_rx;

  // Derived state
  ifrc_mode_e mode;
  logic rx_mode;
  logic tx_mode;
  logic match;
  logic [1:0] thr_need;
  logic level_reached;
  logic signal_level_interrupt;
  logic irq0_d;
  logic irq1_d;

  // Upper address bits must be zero for a hit; only the low byte lane carries data
  assign addr8 = 8'(paddr_i);
  assign access = psel_i && penable_i;
  assign setup = psel_i && !penable_i;
  assign mapped = (paddr_i >> 8) == '0 &&
                  (addr8 == ADDR_IRQ_SEL || addr8 == ADDR_FILL_CTRL ||
                   addr8 == ADDR_TX_OPT || addr8 == ADDR_RX_FILT);
  assign wr = ce_i && access && pwrite_i && mapped && pstrb_i[0];
  assign wbyte = pwdata_i[7:0];
  assign wr_irq_sel = wr && addr8 == ADDR_IRQ_SEL;
  assign wr_fill = wr && addr8 == ADDR_FILL_CTRL;
  assign wr_tx = wr && addr8 == ADDR_TX_OPT;
  assign wr_rx = wr && addr8 == ADDR_RX_FILT;

  // Zero wait states: read data is captured in the setup cycle
  assign pready_o = 1'b1;
  assign pslverr_o = access && !mapped;
  assign prdata_o = prdata_q;

  assign mode = ifrc_mode_e'(chip_mode_i);
  assign rx_mode = mode == IFRC_RECEIVE;
  assign tx_mode = mode == IFRC_TRANSMIT;

  // Sync word comparator
  ifrc_sync_match #(
    .MAX_BYTES(4)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .bit_i(demod_bit_i),
    .bit_valid_i(demod_bit_valid_i),
    .pattern_i(pattern_i),
    .size_sel_i(pattern_size_i),
    .match_o(match)
  );
  assign sync_match_o = match;

  // Selector fields and option bytes
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      rx_irq0_sel_q <= RST_IRQ_SEL[RX_IRQ0_LSB +: 2];
      rx_irq1_sel_q <= RST_IRQ_SEL[RX_IRQ1_LSB +: 2];
      tx_irq1_sel_q <= RST_IRQ_SEL[TX_IRQ1_BIT];
      start_fill_q <= RST_FILL_CTRL[START_FILL_BIT];
      start_full_q <= RST_FILL_CTRL[START_FULL_BIT];
      signal_level_irq_enable_q <= RST_FILL_CTRL[LEVEL_IRQ_EN_BIT];
      signal_level_threshold_sel_q <= RST_FILL_CTRL[LEVEL_THR_LSB +: 2];
      tx_opt_q <= RST_TX_OPT;
      rx_filt_q <= RST_RX_FILT;
    end else begin
      if (wr_irq_sel) begin
        rx_irq0_sel_q <= wbyte[RX_IRQ0_LSB +: 2];
        rx_irq1_sel_q <= wbyte[RX_IRQ1_LSB +: 2];
        tx_irq1_sel_q <= wbyte[TX_IRQ1_BIT];
      end
      if (wr_fill) begin
        start_fill_q <= wbyte[START_FILL_BIT];
        start_full_q <= wbyte[START_FULL_BIT];
        signal_level_irq_enable_q <= wbyte[LEVEL_IRQ_EN_BIT];
        signal_level_threshold_sel_q <= wbyte[LEVEL_THR_LSB +: 2];
      end
      if (wr_tx) begin
        tx_opt_q <= wbyte;  // Reserved bits are kept and read back
      end
      if (wr_rx) begin
        rx_filt_q <= wbyte;
      end
    end
  end

  // Overrun is sticky; a new overrun in the clearing cycle wins
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      overrun_q <= RST_IRQ_SEL[OVERRUN_BIT];
      flush_q <= 1'b0;
    end else if (ce_i) begin
      flush_q <= wr_irq_sel && wbyte[OVERRUN_BIT] && overrun_q;
      if (fifo_overrun_i) begin
        overrun_q <= 1'b1;
      end else if (wr_irq_sel && wbyte[OVERRUN_BIT]) begin
        overrun_q <= 1'b0;
      end
    end
  end
  assign fifo_flush_o = flush_q;

  // Start bit: pattern armed when fill mode is 0, host level when 1
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      start_detect_q <= RST_FILL_CTRL[START_DETECT_BIT];
    end else if (ce_i) begin
      if (start_fill_q) begin
        if (wr_fill) begin
          start_detect_q <= wbyte[START_DETECT_BIT];
        end
      end else if (match && rx_mode) begin
        start_detect_q <= 1'b1;
      end else if (wr_fill && wbyte[START_DETECT_BIT]) begin
        start_detect_q <= 1'b0;
      end
    end
  end
  // Both fill modes reduce to the start bit being high
  assign fifo_fill_en_o = start_detect_q;

  // Threshold codes 00 and 01 both mean level one
  assign thr_need = (signal_level_threshold_sel_q == SEL_OFF) ? SEL_ONE : signal_level_threshold_sel_q;
  assign level_reached = power_level_i >= thr_need;

  // Level hit flag is sticky; detection beats a clear in the same cycle
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      signal_level_hit_flag_q <= RST_FILL_CTRL[LEVEL_HIT_BIT];
    end else if (ce_i) begin
      if (level_reached) begin
        signal_level_hit_flag_q <= 1'b1;
      end else if (wr_fill && wbyte[LEVEL_HIT_BIT]) begin
        signal_level_hit_flag_q <= 1'b0;
      end
    end
  end
  assign signal_level_interrupt = signal_level_hit_flag_q && signal_level_irq_enable_q;

  // Pin mapping by mode; sleep and standby hold both pins low
  always_comb begin
    irq0_d = 1'b0;
    irq1_d = 1'b0;
    if (rx_mode && !buffered_i) begin
      irq0_d = (rx_irq0_sel_q == SEL_ONE) ? signal_level_interrupt : match;
      irq1_d = recovered_bit_clock_i;
    end else if (rx_mode) begin
      case (rx_irq0_sel_q)
        SEL_OFF: irq0_d = 1'b0;
        SEL_ONE: irq0_d = byte_written_i;
        SEL_TWO: irq0_d = fifo_not_empty_i;
        default: irq0_d = match;
      endcase
      case (rx_irq1_sel_q)
        SEL_OFF: irq1_d = 1'b0;
        SEL_ONE: irq1_d = fifo_full_i;
        default: irq1_d = signal_level_interrupt;
      endcase
    end else if (tx_mode && !buffered_i) begin
      irq0_d = 1'b0;
      irq1_d = recovered_bit_clock_i;
    end else if (tx_mode) begin
      irq0_d = fifo_not_empty_i;
      irq1_d = tx_irq1_sel_q ? tx_stopped_i : fifo_full_i;
    end
  end

  // Pins come from flops, one cycle behind their sources
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      irq0_q <= 1'b0;
      irq1_q <= 1'b0;
    end else if (ce_i) begin
      irq0_q <= irq0_d;
      irq1_q <= irq1_d;
    end
  end
  assign irq0_o = irq0_q;
  assign irq1_o = irq1_q;

  // Buffered transmit start policy
  assign tx_start_o = tx_mode && buffered_i && (start_full_q ? fifo_not_empty_i : fifo_full_i);

  // Option outputs
  assign tx_power_sel_o = tx_opt_q[TX_POWER_LSB +: 2];
  assign carrier_only_o = tx_opt_q[NO_MODUL_BIT];
  assign shaping_en_o = tx_opt_q[SHAPING_BIT];
  assign bsync_noisy_o = tx_opt_q[BSYNC_NOISY_BIT];
  assign bitsync_off_o = rx_filt_q[BSYNC_OFF_BIT];
  assign widest_filter_force_o = rx_filt_q[WIDEST_BIT];
  // Force bit overrides the stored width code without altering it
  assign baseband_width_sel_o = rx_filt_q[WIDEST_BIT] ? BW_WIDEST : rx_filt_q[BW_SEL_LSB +: 2];

  // Read data captured at setup; status bits reflect live state
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      prdata_q <= 32'h0000_0000;
    end else if (ce_i && setup) begin
      case (addr8)
        ADDR_IRQ_SEL: prdata_q <= {24'h00_0000, rx_irq0_sel_q, rx_irq1_sel_q, tx_irq1_sel_q,
                                   fifo_full_i, fifo_not_empty_i, overrun_q};
        ADDR_FILL_CTRL: prdata_q <= {24'h00_0000, start_fill_q, start_detect_q, tx_stopped_i,
                                     start_full_q, signal_level_irq_enable_q, signal_level_hit_flag_q,
                                     signal_level_threshold_sel_q};
        ADDR_TX_OPT: prdata_q <= {24'h00_0000, tx_opt_q};
        ADDR_RX_FILT: prdata_q <= {24'h00_0000, rx_filt_q};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_clear_overrun;
    ce_i && wr_irq_sel && wbyte[OVERRUN_BIT] && overrun_q && !fifo_overrun_i;
  endsequence
  sequence s_flushed;
    fifo_flush_o && !overrun_q;
  endsequence

  rx_cont_irq0_a: assert property (ce_i && rx_mode && !buffered_i |=>
    irq0_o == ($past(rx_irq0_sel_q) == SEL_ONE ? $past(signal_level_interrupt) : $past(match)))
    else $error("irq0 wrong in receive continuous");
  rx_buf_irq0_a: assert property (ce_i && rx_mode && buffered_i && rx_irq0_sel_q == SEL_TWO |=>
    irq0_o == $past(fifo_not_empty_i))
    else $error("irq0 does not follow fifo not empty");
  rx_cont_irq1_a: assert property (ce_i && rx_mode && !buffered_i |=>
    irq1_o == $past(recovered_bit_clock_i))
    else $error("irq1 does not follow bit clock");
  rx_buf_irq1_a: assert property (ce_i && rx_mode && buffered_i && rx_irq1_sel_q == SEL_ONE |=>
    irq1_o == $past(fifo_full_i))
    else $error("irq1 does not follow fifo full");
  tx_cont_pins_a: assert property (ce_i && tx_mode && !buffered_i |=> !irq0_o)
    else $error("irq0 not low in transmit continuous");
  tx_buf_irq1_a: assert property (ce_i && tx_mode && buffered_i && tx_irq1_sel_q |=>
    irq1_o == $past(tx_stopped_i))
    else $error("irq1 does not follow tx stopped");
  overrun_flush_a: assert property (s_clear_overrun |=> s_flushed ##1 !fifo_flush_o)
    else $error("overrun clear did not flush once");
  level_hit_a: assert property (ce_i && level_reached |=> signal_level_hit_flag_q [*1] ##0
    signal_level_interrupt == signal_level_irq_enable_q)
    else $error("level hit not set or irq not gated");
  sticky_hold_a: assert property (signal_level_hit_flag_q && !(wr_fill && wbyte[LEVEL_HIT_BIT])
    |=> signal_level_hit_flag_q)
    else $error("level hit flag dropped without clear");
  start_arm_a: assert property (ce_i && !start_fill_q && match && rx_mode |=> fifo_fill_en_o)
    else $error("start sequence did not start filling");
  tx_start_a: assert property (tx_mode && buffered_i && !start_full_q |-> tx_start_o == fifo_full_i)
    else $error("tx start ignores full policy");
  widest_a: assert property (widest_filter_force_o |-> baseband_width_sel_o == BW_WIDEST)
    else $error("width not forced to widest");

endmodule
`default_nettype wire

// ### pkg/ifrc_pkg.sv
// Constants shared by the interrupt, FIFO and transceiver option register bank
package ifrc_pkg;

  // Register indices as printed; byte address on APB is four times the index
  localparam int unsigned IDX_IRQ_SEL = 5;
  localparam int unsigned IDX_FILL_CTRL = 6;
  localparam int unsigned IDX_TX_OPT = 7;
  localparam int unsigned IDX_RX_FILT = 8;
  localparam logic [7:0] ADDR_IRQ_SEL = 8'(4 * IDX_IRQ_SEL);
  localparam logic [7:0] ADDR_FILL_CTRL = 8'(4 * IDX_FILL_CTRL);
  localparam logic [7:0] ADDR_TX_OPT = 8'(4 * IDX_TX_OPT);
  localparam logic [7:0] ADDR_RX_FILT = 8'(4 * IDX_RX_FILT);

  // Values after reset
  localparam logic [7:0] RST_IRQ_SEL = 8'h00;
  localparam logic [7:0] RST_FILL_CTRL = 8'h00;
  localparam logic [7:0] RST_TX_OPT = 8'h00;
  localparam logic [7:0] RST_RX_FILT = 8'h00;

  // Field positions, interrupt source select byte
  localparam int unsigned RX_IRQ0_LSB = 6;
  localparam int unsigned RX_IRQ1_LSB = 4;
  localparam int unsigned TX_IRQ1_BIT = 3;
  localparam int unsigned FIFO_FULL_BIT = 2;
  localparam int unsigned FIFO_NEMPTY_BIT = 1;
  localparam int unsigned OVERRUN_BIT = 0;

  // Field positions, fill and signal level control byte
  localparam int unsigned START_FILL_BIT = 7;
  localparam int unsigned START_DETECT_BIT = 6;
  localparam int unsigned TX_STOPPED_BIT = 5;
  localparam int unsigned START_FULL_BIT = 4;
  localparam int unsigned LEVEL_IRQ_EN_BIT = 3;
  localparam int unsigned LEVEL_HIT_BIT = 2;
  localparam int unsigned LEVEL_THR_LSB = 0;

  // Field positions, transmit options byte
  localparam int unsigned TX_POWER_LSB = 6;
  localparam int unsigned NO_MODUL_BIT = 5;
  localparam int unsigned SHAPING_BIT = 4;
  localparam int unsigned BSYNC_NOISY_BIT = 1;

  // Field positions, receive filter byte
  localparam int unsigned BSYNC_OFF_BIT = 7;
  localparam int unsigned BW_SEL_LSB = 5;
  localparam int unsigned WIDEST_BIT = 4;

  // Two-bit selector codes
  localparam logic [1:0] SEL_OFF = 2'h0;
  localparam logic [1:0] SEL_ONE = 2'h1;
  localparam logic [1:0] SEL_TWO = 2'h2;
  localparam logic [1:0] BW_WIDEST = 2'h3;

  // Transceiver modes
  typedef enum logic [1:0] {
    IFRC_SLEEP = 2'b00,
    IFRC_RECEIVE = 2'b01,
    IFRC_TRANSMIT = 2'b10,
    IFRC_STANDBY = 2'b11
  } ifrc_mode_e;

endpackage

// ### src/ifrc_sync_match.sv
// Sync word comparator over the last demodulated bits
`timescale 1ns/1ns
`default_nettype none
module ifrc_sync_match
  import ifrc_pkg::*;
#(
  parameter int unsigned MAX_BYTES = 4
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // Demodulated stream
  input wire logic bit_i,
  input wire logic bit_valid_i,
  // Reference pattern, first byte in the top bits
  input wire logic [8*MAX_BYTES-1:0] pattern_i,
  input wire logic [1:0] size_sel_i,
  // Match pulse
  output logic match_o
);

  localparam int unsigned W = 8 * MAX_BYTES;

  if (MAX_BYTES != 4) begin : g_chk
    $error("ifrc_sync_match serves a four byte pattern only");
  end

  logic [W-1:0] hist_q;
  logic [W-1:0] hist_d;
  logic [5:0] seen_q;
  logic [MAX_BYTES-1:0] hit;

  // Newest bit enters at the bottom, so the oldest compared bit meets the pattern MSB
  assign hist_d = {hist_q[W-2:0], bit_i};
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      hist_q <= '0;
      seen_q <= 6'h00;
    end else if (ce_i && bit_valid_i) begin
      hist_q <= hist_d;
      if (seen_q != 6'(W)) begin
        seen_q <= seen_q + 6'h01;
      end
    end
  end

  // Compare with the history including the incoming bit, so the bit that completes a match fires it
  for (genvar n = 0; n < MAX_BYTES; n++) begin : g_len
    assign hit[n] = (hist_d[8*(n+1)-1:0] == pattern_i[W-1 -: 8*(n+1)]) && (seen_q >= 6'(8*(n+1)-1));
  end

  // Registered pulse, one cycle per bit that completes a match
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      match_o <= 1'b0;
    end else if (ce_i) begin
      match_o <= bit_valid_i && hit[size_sel_i];
    end
  end

endmodule
`default_nettype wire

// ### sim/ifrc_host_model.sv
// Host microcontroller model: APB master for the register bank
`timescale 1ns/1ns
`default_nettype none
module ifrc_host_model
  import ifrc_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // APB master side
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [7:0] paddr_o,
  output logic [31:0] pwdata_o,
  output logic [3:0] pstrb_o,
  input wire logic pready_i
);
  // Idle bus at time zero
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h00;
    pwdata_o = 32'h0;
    pstrb_o = 4'hf;
  end

  // One transfer; starts after an edge so back to back calls never collide
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_i);
    psel_o <= 1'b1;
    pwrite_o <= wr;
    paddr_o <= addr;
    pwdata_o <= {24'h0, data};
    @(posedge clk_i);
    penable_o <= 1'b1;
    // Request held until pready is seen at a rising edge
    do @(posedge clk_i); while (pready_i !== 1'b1);
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask

  // Clearing a sticky flag is a write with ones in its place
  task automatic w1c(input logic [7:0] addr, input logic [7:0] data);
    xfer(1'b1, addr, data);
  endtask

  // Manual fill is started and stopped by plain writes
  task automatic fill(input logic on);
    xfer(1'b1, ADDR_FILL_CTRL, {1'b1, on, 6'h0b});
  endtask
endmodule
`default_nettype wire

// ### sim/test_ifrc_regs.sv
// Self-checking bench of the interrupt, FIFO and option register bank
`timescale 1ns/1ns
`default_nettype none
module test_ifrc_regs;
  import ifrc_pkg::*;
  localparam logic [31:0] SYNC_PAT = 32'hc300_0000;
  logic clk, rstn, psel, penable, pwrite, pready_o, pslverr_o;
  logic ce, dbit, dvalid;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata_o, seed, r;
  logic [3:0] pstrb;
  logic [1:0] mode, power, tx_power_sel_o, bw_o;
  logic buf_m, full, nemp, ovr, bytew, stop, bclk;
  logic irq0_o, irq1_o, fill_en_o, flush_o, tx_start_o, sync_o;
  logic carrier_o, shaping_o, noisy_o, bsoff_o, widest_o;
  int n_fail, check_count, n_flush;
  logic [32:0] exp_q[$];

  // Clock of 8 ns
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  ifrc_host_model host_u (.clk_i(clk), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata), .pstrb_o(pstrb), .pready_i(pready_o));

  // Fixed one-byte sync word; demodulated bits and clock enable come from the bench
  ifrc_regs dut_u (.ref_clk_i(clk), .rstn_i(rstn), .ce_i(ce), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .chip_mode_i(mode), .buffered_i(buf_m),
    .fifo_full_i(full), .fifo_not_empty_i(nemp), .fifo_overrun_i(ovr), .byte_written_i(bytew),
    .tx_stopped_i(stop), .recovered_bit_clock_i(bclk), .demod_bit_i(dbit), .demod_bit_valid_i(dvalid),
    .pattern_i(SYNC_PAT), .pattern_size_i(2'h0), .power_level_i(power), .irq0_o(irq0_o),
    .irq1_o(irq1_o), .fifo_fill_en_o(fill_en_o), .fifo_flush_o(flush_o), .tx_start_o(tx_start_o),
    .sync_match_o(sync_o), .tx_power_sel_o(tx_power_sel_o), .carrier_only_o(carrier_o),
    .shaping_en_o(shaping_o), .bsync_noisy_o(noisy_o), .bitsync_off_o(bsoff_o),
    .baseband_width_sel_o(bw_o), .widest_filter_force_o(widest_o));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Reads note their expected {pslverr, prdata} before the transfer
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    host_u.xfer(1'b0, a, 8'h00);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_u.xfer(1'b1, a, d);
  endtask

  // Read data is taken only at the edge that completes the access
  always @(posedge clk) begin
    if (psel && penable && pready_o === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) chk("unexpected read", 33'h0, 33'h1);
      else chk("read word", exp_q.pop_front(), {pslverr_o, prdata_o});
    end
    if (flush_o === 1'b1) n_flush++;
  end

  // Pin mapping over every mode, buffering and selector, random sources
  task automatic sweep(input logic lvl);
    logic [1:0] e;
    for (int m = 0; m < 4; m++) for (int b = 0; b < 2; b++) for (int s = 0; s < 4; s++) begin
      r = xs();
      wr(ADDR_IRQ_SEL, {2'(s), 2'(s), 1'(s), 3'b000});
      @(posedge clk);
      mode <= 2'(m);
      buf_m <= 1'(b);
      {bclk, stop, bytew, nemp, full} <= r[4:0];
      repeat (3) @(posedge clk);
      #1;
      e = 2'b00;
      if (m == 1 && b == 0) e = {r[4], s == 1 ? lvl : 1'b0};
      if (m == 1 && b == 1) e = {s == 0 ? 1'b0 : s == 1 ? r[0] : lvl, s == 1 ? r[2] : s == 2 ? r[1] : 1'b0};
      if (m == 2 && b == 0) e = {r[4], 1'b0};
      if (m == 2 && b == 1) e = {s[0] ? r[3] : r[0], r[1]};
      chk("irq pins", 33'(e), 33'({irq1_o, irq0_o}));
    end
    $display("test mapping done");
  endtask

  // Watchdog well beyond the expected run of about a thousand cycles
  initial begin
    #(8 * 40000);
    n_fail++;
    end_sim();
  end

  initial begin
    seed = 32'hbf1d479e;
    rstn = 1'b0;
    {mode, power, buf_m, full, nemp, ovr, bytew, stop, bclk} = 11'h000;
    {ce, dbit, dvalid} = 3'b100;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    // Reset values and an unmapped word
    rd(ADDR_IRQ_SEL, 33'h0);
    rd(ADDR_FILL_CTRL, 33'h0);
    rd(ADDR_TX_OPT, 33'h0);
    rd(ADDR_RX_FILT, 33'h0);
    rd(8'h24, 33'h100000000);
    $display("test reset done");
    // Option bytes written with random values, reserved bits kept
    for (int i = 0; i < 6; i++) begin
      r = xs();
      wr(ADDR_TX_OPT, r[7:0]);
      wr(ADDR_RX_FILT, r[15:8]);
      rd(ADDR_TX_OPT, 33'(r[7:0]));
      rd(ADDR_RX_FILT, 33'(r[15:8]));
      chk("tx fields", 33'(r[7:4]), 33'({tx_power_sel_o, carrier_o, shaping_o}));
      chk("sync noisy", 33'(r[1]), 33'(noisy_o));
      chk("width", 33'({r[15], r[12] ? 2'b11 : r[14:13], r[12]}), 33'({bsoff_o, bw_o, widest_o}));
    end
    // Clock enable low freezes the bank: the write is dropped
    ce <= 1'b0;
    wr(ADDR_TX_OPT, ~r[7:0]);
    ce <= 1'b1;
    rd(ADDR_TX_OPT, 33'(r[7:0]));
    $display("test options done");
    sweep(1'b0);
    // Threshold codes against every power level, receive mode
    @(posedge clk);
    {mode, buf_m, stop} <= 4'b0100;
    for (int t = 0; t < 4; t++) for (int p = 0; p < 4; p++) begin
      @(posedge clk);
      power <= 2'h0;
      host_u.w1c(ADDR_FILL_CTRL, 8'(4 | t));
      @(posedge clk);
      power <= 2'(p);
      repeat (3) @(posedge clk);
      rd(ADDR_FILL_CTRL, 33'(((p >= t && p > 0) ? 4 : 0) | t));
    end
    @(posedge clk);
    power <= 2'h0;
    wr(ADDR_FILL_CTRL, 8'h0b);
    rd(ADDR_FILL_CTRL, 33'h0f);
    $display("test level done");
    wr(ADDR_FILL_CTRL, 8'h03);
    sweep(1'b0);
    wr(ADDR_FILL_CTRL, 8'h0b);
    sweep(1'b1);
    // Overrun, read-only flags and stopped flag
    @(posedge clk);
    {full, nemp, stop, ovr} <= 4'b0001;
    @(posedge clk);
    ovr <= 1'b0;
    wr(ADDR_IRQ_SEL, 8'h00);
    rd(ADDR_IRQ_SEL, 33'h01);
    chk("no flush", 33'h0, 33'(n_flush));
    wr(ADDR_IRQ_SEL, 8'h01);
    repeat (3) @(posedge clk);
    chk("flush count", 33'h1, 33'(n_flush));
    {full, nemp, stop} <= 3'b111;
    wr(ADDR_IRQ_SEL, 8'hff);
    rd(ADDR_IRQ_SEL, 33'hfe);
    rd(ADDR_FILL_CTRL, 33'h2f);
    $display("test flags done");
    // Transmit start policy, buffered transmit
    {mode, buf_m, full} <= 4'b1010;
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_FILL_CTRL, k[1] ? 8'h1b : 8'h0b);
      full <= k[0];
      repeat (2) @(posedge clk);
      #1;
      chk("tx start", 33'(k[1] | k[0]), 33'(tx_start_o));
    end
    // Manual fill: the mode bit takes effect from the next write, which then starts filling
    host_u.fill(1'b0);
    host_u.fill(1'b1);
    @(posedge clk);
    #1;
    chk("fill on", 33'h1, 33'(fill_en_o));
    host_u.fill(1'b0);
    @(posedge clk);
    #1;
    chk("fill off", 33'h0, 33'(fill_en_o));
    // Pattern mode in receive: the sync byte goes out first bit first and arms filling
    wr(ADDR_FILL_CTRL, 8'h0b);
    mode <= 2'b01;
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk);
      dbit <= SYNC_PAT[24 + i];
      dvalid <= 1'b1;
    end
    @(posedge clk);
    dvalid <= 1'b0;
    #1;
    chk("sync match", 33'h1, 33'(sync_o));
    @(posedge clk);
    #1;
    chk("fill armed", 33'h1, 33'(fill_en_o));
    host_u.w1c(ADDR_FILL_CTRL, 8'h4b);
    rd(ADDR_FILL_CTRL, 33'h2f);
    chk("fill idle", 33'h0, 33'(fill_en_o));
    repeat (2) @(posedge clk);
    chk("notes left", 33'h0, 33'(exp_q.size()));
    $display("test fill done");
    end_sim();
  end
endmodule
`default_nettype wire
